// *** verilog/gio_pkg.sv ***
/*
 * Shared constants and carrier types for the general-purpose pin block with
 * input qualification and debug pin multiplexing.
 * Assumes a single system clock and a plain word-wide register port.
 */
package gio_pkg;

    localparam int GIO_ADDR_W = 8;
    localparam int GIO_DATA_W = 32;
    localparam int GIO_GROUP_PINS = 8;
    localparam int GIO_PERIOD_W = 8;
    localparam int GIO_SCNT_W = 9;
    localparam int GIO_MATCH_W = 3;

    // Register byte offsets.
    localparam logic [7:0] GIO_OFF_GROUP_CTRL = 8'h00;
    localparam logic [7:0] GIO_OFF_COUNT_SEL = 8'h04;
    localparam logic [7:0] GIO_OFF_QUAL_EN = 8'h08;
    localparam logic [7:0] GIO_OFF_DIR = 8'h0C;
    localparam logic [7:0] GIO_OFF_DATA_OUT = 8'h10;
    localparam logic [7:0] GIO_OFF_MUX_SEL = 8'h14;
    localparam logic [7:0] GIO_OFF_PULLUP = 8'h18;
    localparam logic [7:0] GIO_OFF_PIN_LEVEL = 8'h1C;
    localparam logic [7:0] GIO_OFF_DEBUG_CTRL = 8'h20;

    // Field positions and reset values.
    localparam int GIO_DBGCTL_COMPACT_BIT = 0;
    localparam logic [31:0] GIO_RST_ZERO = 32'h0000_0000;
    localparam logic [GIO_PERIOD_W-1:0] GIO_PERIOD_ZERO = 8'h00;

    // Matching samples needed before a new level passes (count minus one).
    localparam logic [GIO_MATCH_W-1:0] GIO_MATCH_THREE = 3'h2;
    localparam logic [GIO_MATCH_W-1:0] GIO_MATCH_SIX = 3'h5;

    // Pin multiplexer selections.
    typedef enum logic [1:0] {
        GIO_MUX_GPIO = 2'h0,
        GIO_MUX_PERIPH = 2'h1,
        GIO_MUX_OUT_XBAR = 2'h2,
        GIO_MUX_DEBUG = 2'h3
    } gio_mux_t;

    typedef struct packed {
        logic [GIO_ADDR_W-1:0] addr;
        logic [GIO_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } gio_bus_req_t;

    typedef struct packed {
        logic tdo;
        logic tdo_en;
    } gio_dbg_drive_t;

endpackage

// *** verilog/gio_qualifier.sv ***
/*
 * One pin's input qualifier: a saturating count of matching samples taken
 * on the group strobe, or plain synchronous pass-through.
 * Assumes its input is already synchronised to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module gio_qualifier (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sample_stb,
    input wire logic qual_en,
    input wire logic six_samples,
    input wire logic sync_in,
    output logic level
);
    import gio_pkg::*;

    logic last_r;
    logic [GIO_MATCH_W-1:0] match_r;
    logic [GIO_MATCH_W-1:0] need;

    // (R5) three or six samples
    assign need = six_samples ? GIO_MATCH_SIX : GIO_MATCH_THREE;

    // (R16) matching sample count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            last_r <= 1'b0;
            match_r <= '0;
        end else if (sample_stb) begin
            last_r <= sync_in;
            if (sync_in != last_r) begin
                match_r <= '0;
            end else if (match_r != GIO_MATCH_SIX) begin
                match_r <= match_r + 3'h1;
            end
        end
    end

    // (R6) level passes after window
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level <= 1'b0;
        end else if (!qual_en) begin
            level <= sync_in;
        end else if (sample_stb && sync_in == last_r && match_r + 3'h1 >= need) begin
            level <= last_r;
        end
    end

    a_qual_on_strobe: assert property (@(posedge core_clk) disable iff (sys_rst) // (R6)
        (qual_en && $past(qual_en) && $changed(level)) |-> $past(sample_stb))
        else $error("qualified level changed without a sample strobe");

    a_three_samples: assert property (@(posedge core_clk) disable iff (sys_rst) // (R5)
        (qual_en && !six_samples && sample_stb && sync_in == last_r && match_r == 3'h1)
        |=> level == $past(last_r))
        else $error("three-sample match did not pass the level");

    a_six_not_early: assert property (@(posedge core_clk) disable iff (sys_rst) // (R5)
        (qual_en && six_samples && $past(qual_en) && $past(six_samples) && $changed(level))
        |-> $past(match_r) >= 3'h4)
        else $error("six-sample mode passed a level too early");

    c_six_pass: cover property (@(posedge core_clk) disable iff (sys_rst)
        qual_en && six_samples && $changed(level));

    c_glitch_drop: cover property (@(posedge core_clk) disable iff (sys_rst)
        qual_en && sample_stb && sync_in != last_r && match_r == 3'h1);

endmodule

`default_nettype wire

// *** verilog/gio_port.sv ***
/*
 * General-purpose pin port: register file, per-group sampling strobes,
 * per-pin qualifiers, pin multiplexing and the debug data pin release.
 * Assumes a register master that never issues read and write together and
 * pins that may change at any time relative to core_clk.
 */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) After reset every pin is an input until software changes direction or function.
// (R2) Each group period field takes any value from 0x00 to 0xFF.
// (R3) Period zero samples every cycle and period n samples once every 2n cycles.
// (R4) One period field governs a whole group of eight adjacent pins.
// (R5) A per-pin select chooses three or six samples to validate a change.
// (R6) A new level passes only after holding for the period times samples minus one.
// (R7) The driver holds a level two cycles unqualified, or window plus period plus one qualified.
// (R8) Each pin is shared between its general-purpose function and peripheral signals by the mux.
// (R9) A mux option drives the pin from the output crossbar.
// (R10) Every pin level is delivered to the input crossbar.
// (R11) The debug port speaks four-wire or two-wire protocol as the probe chooses.
// (R12) In the compact two-pin mode the debug data pins are free for general-purpose use.
// (R13) The debug data input function is the reset mux choice with its pullup off.
// (R14) The debug data output is the reset choice, tri-stated when idle, pullup off.
// (R15) Software or the board should pull up the debug data input when it is used.
// (R16) Each group strobes from a counter and each pin counts matching samples.
// (R17) Pin inputs pass a two-stage synchroniser before qualifier or crossbars.
module gio_port #(
    parameter int NUM_PINS = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire gio_pkg::gio_bus_req_t bus_req,
    output logic [gio_pkg::GIO_DATA_W-1:0] bus_rdata,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe_n,
    output logic [NUM_PINS-1:0] pin_pullup_en,
    input wire logic [NUM_PINS-1:0] periph_out,
    input wire logic [NUM_PINS-1:0] periph_oe,
    input wire logic [NUM_PINS-1:0] xbar_out,
    output logic [NUM_PINS-1:0] xbar_in_level,
    input wire gio_pkg::gio_dbg_drive_t dbg_drive,
    output logic dbg_tdi,
    output logic compact_two_pin_test_mode
);
    import gio_pkg::*;

    localparam int NUM_GROUPS = (NUM_PINS + GIO_GROUP_PINS - 1) / GIO_GROUP_PINS;
    localparam int DBG_IN = NUM_PINS - 2;
    localparam int DBG_OUT = NUM_PINS - 1;

    logic [NUM_GROUPS*GIO_PERIOD_W-1:0] pin_group_control_r;
    logic [NUM_PINS-1:0] qual_sample_count_select_r;
    logic [NUM_PINS-1:0] qual_en_r;
    logic [NUM_PINS-1:0] dir_r;
    logic [NUM_PINS-1:0] data_out_r;
    logic [2*NUM_PINS-1:0] mux_r;
    logic [NUM_PINS-1:0] pullup_r;
    logic compact_r;
    logic [NUM_PINS-1:0] sync1_r;
    logic [NUM_PINS-1:0] sync2_r;
    logic [NUM_PINS-1:0] qual_level;
    logic [NUM_GROUPS-1:0] grp_stb;
    logic [NUM_PINS-1:0] pin_out_nxt;
    logic [NUM_PINS-1:0] pin_oe_n_nxt;
    logic [GIO_DATA_W-1:0] rdata_nxt;
    logic wr_hit_grp;

    assign wr_hit_grp = bus_req.wr && bus_req.addr == GIO_OFF_GROUP_CTRL;

    // (R1) reset as inputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dir_r <= '0;
            data_out_r <= '0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == GIO_OFF_DIR) begin
                dir_r <= bus_req.wdata[NUM_PINS-1:0];
            end
            if (bus_req.addr == GIO_OFF_DATA_OUT) begin
                data_out_r <= bus_req.wdata[NUM_PINS-1:0];
            end
        end
    end

    // (R2) full period range
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_group_control_r <= '0;
            qual_sample_count_select_r <= '0;
            qual_en_r <= '0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == GIO_OFF_GROUP_CTRL) begin
                pin_group_control_r <= bus_req.wdata[NUM_GROUPS*GIO_PERIOD_W-1:0];
            end
            if (bus_req.addr == GIO_OFF_COUNT_SEL) begin
                qual_sample_count_select_r <= bus_req.wdata[NUM_PINS-1:0];
            end
            if (bus_req.addr == GIO_OFF_QUAL_EN) begin
                qual_en_r <= bus_req.wdata[NUM_PINS-1:0];
            end
        end
    end

    // (R13) debug mux default, pullups off
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mux_r <= '0;
            mux_r[2*DBG_IN +: 2] <= GIO_MUX_DEBUG;
            mux_r[2*DBG_OUT +: 2] <= GIO_MUX_DEBUG;
            pullup_r <= '0;
            compact_r <= 1'b0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == GIO_OFF_MUX_SEL) begin
                mux_r <= bus_req.wdata[2*NUM_PINS-1:0];
            end
            if (bus_req.addr == GIO_OFF_PULLUP) begin
                pullup_r <= bus_req.wdata[NUM_PINS-1:0];
            end
            if (bus_req.addr == GIO_OFF_DEBUG_CTRL) begin
                compact_r <= bus_req.wdata[GIO_DBGCTL_COMPACT_BIT];
            end
        end
    end

    assign pin_pullup_en = pullup_r;
    // (R11) probe mode to debug subsystem
    assign compact_two_pin_test_mode = compact_r;

    always_comb begin
        rdata_nxt = GIO_RST_ZERO;
        case (bus_req.addr)
            GIO_OFF_GROUP_CTRL: rdata_nxt[NUM_GROUPS*GIO_PERIOD_W-1:0] = pin_group_control_r;
            GIO_OFF_COUNT_SEL: rdata_nxt[NUM_PINS-1:0] = qual_sample_count_select_r;
            GIO_OFF_QUAL_EN: rdata_nxt[NUM_PINS-1:0] = qual_en_r;
            GIO_OFF_DIR: rdata_nxt[NUM_PINS-1:0] = dir_r;
            GIO_OFF_DATA_OUT: rdata_nxt[NUM_PINS-1:0] = data_out_r;
            GIO_OFF_MUX_SEL: rdata_nxt[2*NUM_PINS-1:0] = mux_r;
            GIO_OFF_PULLUP: rdata_nxt[NUM_PINS-1:0] = pullup_r;
            GIO_OFF_PIN_LEVEL: rdata_nxt[NUM_PINS-1:0] = xbar_in_level;
            GIO_OFF_DEBUG_CTRL: rdata_nxt[GIO_DBGCTL_COMPACT_BIT] = compact_r;
            default: rdata_nxt = GIO_RST_ZERO;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_rdata <= GIO_RST_ZERO;
        end else if (bus_req.rd) begin
            bus_rdata <= rdata_nxt;
        end else begin
            bus_rdata <= GIO_RST_ZERO;
        end
    end

    // (R17) two-stage synchroniser
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    genvar g;
    genvar p;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
            logic [GIO_SCNT_W-1:0] cnt_r;
            logic [GIO_SCNT_W-1:0] last_cnt;
            logic [GIO_PERIOD_W-1:0] prd;
            assign prd = pin_group_control_r[g*GIO_PERIOD_W +: GIO_PERIOD_W];
            assign last_cnt = {prd, 1'b0} - 9'h001;
            // (R3) strobe every cycle or every 2n cycles
            assign grp_stb[g] = (prd == GIO_PERIOD_ZERO) || (cnt_r == last_cnt);
            // (R16) group sampling counter
            always_ff @(posedge core_clk) begin
                if (sys_rst || grp_stb[g]) begin
                    cnt_r <= '0;
                end else begin
                    cnt_r <= cnt_r + 9'h001;
                end
            end

            a_period_one: assert property (@(posedge core_clk) disable iff (sys_rst) // (R3)
                (prd == 8'h01 && $past(prd == 8'h01) && grp_stb[g]) |=> (prd != 8'h01) or (!grp_stb[g] ##1 grp_stb[g]))
                else $error("period one did not strobe every second cycle");

            a_period_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // (R3)
                (prd == 8'h00) |-> grp_stb[g])
                else $error("period zero did not strobe every cycle");

            c_period_max: cover property (@(posedge core_clk) disable iff (sys_rst)
                prd == 8'hFF && grp_stb[g]);
        end

        for (p = 0; p < NUM_PINS; p++) begin : gen_pin
            // (R4) group strobe shared by eight pins
            gio_qualifier u_qual (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .sample_stb(grp_stb[p / GIO_GROUP_PINS]),
                .qual_en(qual_en_r[p]),
                .six_samples(qual_sample_count_select_r[p]),
                .sync_in(sync2_r[p]),
                .level(qual_level[p])
            );
        end
    endgenerate

    // (R10) levels to the input crossbar
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            xbar_in_level <= '0;
            dbg_tdi <= 1'b0;
        end else begin
            xbar_in_level <= qual_level;
            dbg_tdi <= sync2_r[DBG_IN];
        end
    end

    // (R8) pin multiplexer
    always_comb begin
        pin_out_nxt = '0;
        pin_oe_n_nxt = '1;
        for (int i = 0; i < NUM_PINS; i++) begin
            case (gio_mux_t'(mux_r[2*i +: 2]))
                GIO_MUX_PERIPH: begin
                    pin_out_nxt[i] = periph_out[i];
                    pin_oe_n_nxt[i] = ~periph_oe[i];
                end
                // (R9) output crossbar drive
                GIO_MUX_OUT_XBAR: begin
                    pin_out_nxt[i] = xbar_out[i];
                    pin_oe_n_nxt[i] = ~dir_r[i];
                end
                GIO_MUX_DEBUG: begin
                    pin_out_nxt[i] = data_out_r[i];
                    pin_oe_n_nxt[i] = ~dir_r[i];
                    // (R12) compact mode releases the data pins
                    if (!compact_r && i == DBG_IN) begin
                        pin_oe_n_nxt[i] = 1'b1;
                    end
                    // (R14) data output tri-stated when idle
                    if (!compact_r && i == DBG_OUT) begin
                        pin_out_nxt[i] = dbg_drive.tdo;
                        pin_oe_n_nxt[i] = ~dbg_drive.tdo_en;
                    end
                end
                default: begin
                    pin_out_nxt[i] = data_out_r[i];
                    pin_oe_n_nxt[i] = ~dir_r[i];
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_out <= '0;
            pin_oe_n <= '1;
        end else begin
            pin_out <= pin_out_nxt;
            pin_oe_n <= pin_oe_n_nxt;
        end
    end

    a_reset_inputs: assert property (@(posedge core_clk) // (R1)
        $past(sys_rst) && !sys_rst |-> dir_r == '0 && pin_oe_n == '1)
        else $error("pins not inputs after reset");

    a_debug_defaults: assert property (@(posedge core_clk) // (R13)
        $past(sys_rst) && !sys_rst |-> mux_r[2*DBG_IN +: 2] == GIO_MUX_DEBUG && pullup_r == '0)
        else $error("debug data input default wrong after reset");

    a_period_write: assert property (@(posedge core_clk) disable iff (sys_rst) // (R2)
        wr_hit_grp |=> pin_group_control_r[GIO_PERIOD_W-1:0] == $past(bus_req.wdata[GIO_PERIOD_W-1:0]))
        else $error("group period field did not take written value");

    a_tdo_tristate: assert property (@(posedge core_clk) disable iff (sys_rst) // (R14)
        (!compact_r && mux_r[2*DBG_OUT +: 2] == GIO_MUX_DEBUG && !dbg_drive.tdo_en) |=> pin_oe_n[DBG_OUT])
        else $error("debug data output driven while idle");

    a_compact_release: assert property (@(posedge core_clk) disable iff (sys_rst) // (R12)
        (compact_r && mux_r[2*DBG_IN +: 2] == GIO_MUX_DEBUG && dir_r[DBG_IN]) |=> !pin_oe_n[DBG_IN])
        else $error("compact mode did not release the data input pin");

    a_xbar_drive: assert property (@(posedge core_clk) disable iff (sys_rst) // (R9)
        (mux_r[13:12] == GIO_MUX_OUT_XBAR && dir_r[6]) |=> pin_out[6] == $past(xbar_out[6]) && !pin_oe_n[6])
        else $error("output crossbar not routed to pin");

    a_periph_share: assert property (@(posedge core_clk) disable iff (sys_rst) // (R8)
        (mux_r[9:8] == GIO_MUX_PERIPH) |=> pin_out[4] == $past(periph_out[4]) && pin_oe_n[4] == !$past(periph_oe[4]))
        else $error("peripheral signal not routed to pin");

    a_level_read: assert property (@(posedge core_clk) disable iff (sys_rst) // (R10)
        (bus_req.rd && bus_req.addr == GIO_OFF_PIN_LEVEL) |=> bus_rdata[NUM_PINS-1:0] == $past(xbar_in_level))
        else $error("pin level read does not match crossbar level");

    c_compact_mode: cover property (@(posedge core_clk) disable iff (sys_rst)
        compact_r && !pin_oe_n[DBG_OUT]);

    c_tdo_drive: cover property (@(posedge core_clk) disable iff (sys_rst)
        !compact_r && !pin_oe_n[DBG_OUT]);

endmodule

`default_nettype wire

// *** tb/gio_far_side.sv ***
/*
 * Far-side model: external drivers on the pins and the debug probe.
 * Assumes its tasks are called right after a rising core_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none

module gio_far_side #(
    parameter int NUM_PINS = 16
) (
    input wire logic core_clk,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic [NUM_PINS-1:0] pin_pullup_en,
    output logic [NUM_PINS-1:0] pin_in
);
    logic [NUM_PINS-1:0] ext_val = '0;
    logic [NUM_PINS-1:0] ext_drv = '1;
    logic [NUM_PINS-1:0] float_pat = '0;

    // A released line without pullup shows a level that changes every cycle.
    always @(posedge core_clk) begin
        float_pat <= ~float_pat;
    end

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_oe_n[i] === 1'b0) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drv[i]) begin
                pin_in[i] = ext_val[i];
            end else begin
                pin_in[i] = pin_pullup_en[i] | float_pat[i];
            end
        end
    end

    task automatic lines(input logic [NUM_PINS-1:0] v);
        ext_val <= v;
    endtask

    task automatic probe_mode(input logic compact);
        ext_drv[NUM_PINS-2] <= ~compact;
        ext_drv[NUM_PINS-1] <= 1'b0;
    endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for gio_port with a register model and pin model.
 * Assumes gio_pkg, gio_port and gio_far_side are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import gio_pkg::*;
    localparam int NP = 16;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    gio_bus_req_t bus_req = '0;
    logic [GIO_DATA_W-1:0] bus_rdata;
    logic [NP-1:0] pin_in;
    logic [NP-1:0] pin_out;
    logic [NP-1:0] pin_oe_n;
    logic [NP-1:0] pin_pullup_en;
    logic [NP-1:0] xbar_in_level;
    logic [NP-1:0] periph_out = '0;
    logic [NP-1:0] periph_oe = '0;
    logic [NP-1:0] xbar_out = '0;
    logic [NP-1:0] ext = '0;
    logic [NP-1:0] eo;
    logic [NP-1:0] en;
    logic [31:0] dout;
    gio_dbg_drive_t dbg_drive = '0;
    logic dbg_tdi;
    logic compact_two_pin_test_mode;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 71018;
    logic [31:0] mregs [int];

    always #20 core_clk = ~core_clk;

    gio_port #(.NUM_PINS(NP)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .periph_out(periph_out), .periph_oe(periph_oe),
        .xbar_out(xbar_out), .xbar_in_level(xbar_in_level), .dbg_drive(dbg_drive),
        .dbg_tdi(dbg_tdi), .compact_two_pin_test_mode(compact_two_pin_test_mode));

    gio_far_side #(.NUM_PINS(NP)) far_u (.core_clk(core_clk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en), .pin_in(pin_in));

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] rmask(input logic [7:0] a);
        case (a)
            GIO_OFF_MUX_SEL: return 32'hFFFF_FFFF;
            GIO_OFF_DEBUG_CTRL: return 32'h0000_0001;
            GIO_OFF_PIN_LEVEL: return 32'h0000_0000;
            GIO_OFF_GROUP_CTRL, GIO_OFF_COUNT_SEL, GIO_OFF_QUAL_EN: return 32'h0000_FFFF;
            GIO_OFF_DIR, GIO_OFF_DATA_OUT, GIO_OFF_PULLUP: return 32'h0000_FFFF;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        mregs[a] = d & rmask(a);
        @(posedge core_clk);
    endtask

    task automatic reg_chk(input logic [7:0] a);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 check("rdata", bus_rdata, mregs.exists(a) ? mregs[a] : 32'h0000_0000);
        @(posedge core_clk);
        #1 check("rdata idle", bus_rdata, 32'h0000_0000);
        @(posedge core_clk);
    endtask

    task automatic pulse(input int pin, input logic v, input int n);
        ext[pin] = v;
        far_u.lines(ext);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic qual_case(input int pin, input logic [7:0] prd, input logic six);
        int p;
        int w;
        p = (prd == 8'h00) ? 1 : 2 * prd;
        w = p * (six ? 5 : 2);
        reg_wr(GIO_OFF_QUAL_EN, 32'h0000_0001 << pin);
        reg_wr(GIO_OFF_COUNT_SEL, {31'h0000_0000, six} << pin);
        reg_wr(GIO_OFF_GROUP_CTRL, pin < 8 ? {16'h0000, 8'hFF, prd} : {16'h0000, prd, 8'hFF});
        pulse(pin, 1'b0, 1100 + w + p);
        pulse(pin, 1'b1, w - p);
        pulse(pin, 1'b0, w + p + 6);
        #1 check("glitch", xbar_in_level[pin], 1'b0);
        pulse(pin, 1'b1, w);
        #1 check("early", xbar_in_level[pin], 1'b0);
        repeat (p + 6) @(posedge core_clk);
        #1 check("qualified", xbar_in_level[pin], 1'b1);
        pulse(pin, 1'b0, w + p + 6);
        #1 check("qualified low", xbar_in_level[pin], 1'b0);
        @(posedge core_clk);
        $display("test qualify pin %0d period %0d six %0d done", pin, prd, six);
    endtask

    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        conclude();
    end

    initial begin
        mregs[GIO_OFF_MUX_SEL] = 32'hF000_0000;
        far_u.probe_mode(1'b0);
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1 check("oe_n reset", pin_oe_n, 16'hFFFF);
        check("pullup reset", pin_pullup_en, 16'h0000);
        @(posedge core_clk);
        for (int a = 0; a <= 'h24; a += 4) begin
            if (a != GIO_OFF_PIN_LEVEL) reg_chk(a[7:0]);
        end
        $display("test reset done");
        for (int a = 0; a <= 'h24; a += 4) begin
            if (a != GIO_OFF_PIN_LEVEL) begin
                reg_wr(a[7:0], $random(seed));
                reg_chk(a[7:0]);
                reg_wr(a[7:0], a == GIO_OFF_MUX_SEL ? 32'hF000_0000 : 32'h0000_0000);
            end
        end
        $display("test registers done");
        pulse(2, 1'b1, 3);
        #1 check("sync old", xbar_in_level[2], 1'b0);
        @(posedge core_clk);
        #1 check("sync new", xbar_in_level[2], 1'b1);
        @(posedge core_clk);
        repeat (10) begin
            ext[7:0] = $random(seed);
            far_u.lines(ext);
            repeat (6) @(posedge core_clk);
            #1 check("in level", xbar_in_level[7:0], ext[7:0]);
            @(posedge core_clk);
        end
        bus_req.addr <= GIO_OFF_PIN_LEVEL;
        bus_req.rd <= 1'b1;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 check("level read", bus_rdata[14:0], {7'h00, ext[7:0]});
        @(posedge core_clk);
        $display("test sync input done");
        dout = $random(seed);
        reg_wr(GIO_OFF_DATA_OUT, dout);
        reg_wr(GIO_OFF_DIR, 32'h0000_00FF);
        reg_wr(GIO_OFF_MUX_SEL, 32'hF000_A500);
        repeat (6) begin
            periph_out <= $random(seed);
            periph_oe <= $random(seed);
            xbar_out <= $random(seed);
            repeat (2) @(posedge core_clk);
            #1 for (int i = 0; i < 8; i++) begin
                eo[i] = i < 4 ? dout[i] : (i < 6 ? periph_out[i] : xbar_out[i]);
                en[i] = (i == 4 || i == 5) ? ~periph_oe[i] : 1'b0;
            end
            check("oe_n", pin_oe_n[7:0], en[7:0]);
            check("out", pin_out[7:0] & ~en[7:0], eo[7:0] & ~en[7:0]);
            check("loopback", xbar_in_level[3:0], dout[3:0]);
            @(posedge core_clk);
        end
        reg_wr(GIO_OFF_DIR, 32'h0000_0000);
        reg_wr(GIO_OFF_MUX_SEL, 32'hF000_0000);
        $display("test outputs done");
        qual_case(8, 8'h00, 1'b0);
        qual_case(8, 8'h00, 1'b1);
        qual_case(8, 8'h01, 1'b0);
        qual_case(0, 8'h02, 1'b1);
        qual_case(0, 8'hFF, 1'b0);
        reg_wr(GIO_OFF_QUAL_EN, 32'h0000_0000);
        #1 check("tdo idle", pin_oe_n[15], 1'b1);
        @(posedge core_clk);
        reg_wr(GIO_OFF_DIR, 32'h0000_C000);
        reg_wr(GIO_OFF_PULLUP, 32'h0000_4000);
        #1 check("tdi input", pin_oe_n[14], 1'b1);
        check("pullup", pin_pullup_en, 16'h4000);
        @(posedge core_clk);
        dbg_drive <= '{tdo: 1'b1, tdo_en: 1'b1};
        pulse(14, 1'b1, 6);
        #1 check("tdi", dbg_tdi, 1'b1);
        check("tdo en", pin_oe_n[15], 1'b0);
        check("tdo", pin_out[15], 1'b1);
        @(posedge core_clk);
        reg_wr(GIO_OFF_DEBUG_CTRL, 32'h0000_0001);
        far_u.probe_mode(1'b1);
        reg_wr(GIO_OFF_DATA_OUT, 32'h0000_4000);
        @(posedge core_clk);
        #1 check("compact", compact_two_pin_test_mode, 1'b1);
        check("gpio oe_n", pin_oe_n[15:14], 2'b00);
        check("gpio out", pin_out[15:14], 2'b01);
        $display("test debug pins done");
        conclude();
    end
endmodule

`default_nettype wire
